// file: design/pips_input_select.sv
/*
  pips_input_select: routes remappable pins onto peripheral inputs through a bank of
  input-select registers reached over ahb-lite.
  assumes: pins are asynchronous to clk; the system holds the single master and decodes hsel.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - each peripheral input owns its selection field
// - registers hold one or two 6-bit fields
// - field value N routes pin N
// - registers 0-2: triggers and external interrupts
// - registers 3, 4, 23 high: timer clocks
// - capture, fault, ccp clock, logic-cell selections
// - uart and spi selections in their registers
// - reset sets all fields ones, inputs grounded
// - lock resets unlocked, freezes fields when set
module pips_input_select
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [pips_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // remappable pins and routed peripheral inputs
  input wire logic [pips_pkg::PIN_COUNT-1:0] remappablePin,
  output pips_pkg::pips_periph_type periphIn,
  output logic pinMapLock
);
  import pips_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pips_phase_type phase;
  logic [ADDR_W-1:0] dataAddr;
  logic [SEL_W-1:0] sel [FIELD_COUNT];
  logic [PIN_COUNT-1:0] pinS1;
  logic [PIN_COUNT-1:0] pinS2;
  logic [PIN_COUNT-1:0] pinS3;
  logic [PIN_COUNT-1:0] pinLevel;
  logic [FIELD_COUNT-1:0] periphVec;
  logic [FIELD_COUNT-1:0] next_periphVec;
  logic [31:0] next_hrdata;
  logic accept;
  logic writeNow;

  // ------------------------------------------------------------
  // ahb-lite phases
  // ------------------------------------------------------------
  // reads take one wait state so read data come from a flop and always see a write
  // that finished in the cycle before
  assign hreadyout = (phase != PhReadWait);
  assign hresp = 1'b0;
  assign accept = hsel && htrans[1] && hready;
  assign writeNow = (phase == PhWrite);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase <= PhIdle;
      dataAddr <= '0;
    end
    else if (accept)
    begin
      phase <= hwrite ? PhWrite : PhReadWait;
      dataAddr <= haddr;
    end
    else if (phase == PhReadWait)
    begin
      phase <= PhReadDone;
    end
    else
    begin
      phase <= PhIdle;
    end
  end

  // ------------------------------------------------------------
  // selection fields and lock
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < FIELD_COUNT; i++)
      begin
        sel[i] <= SEL_RESET;
      end
    end
    else if (writeNow && !pinMapLock)
    begin
      for (int i = 0; i < FIELD_COUNT; i++)
      begin
        // each field is decoded on its own register and half only
        if (dataAddr == ADDR_W'(FIELD_REG[i] * REG_STRIDE))
        begin
          sel[i] <= FIELD_HI[i] ? hwdata[HI_POS +: SEL_W] : hwdata[LO_POS +: SEL_W];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinMapLock <= LOCK_RESET;
    end
    else if (writeNow && dataAddr == LOCK_ADDR)
    begin
      // a single write to LOCK_ADDR sets or clears the lock from bit LOCK_POS
      pinMapLock <= hwdata[LOCK_POS];
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb
  begin
    next_hrdata = '0;
    if (dataAddr == LOCK_ADDR)
    begin
      next_hrdata[LOCK_POS] = pinMapLock;
    end
    else if (dataAddr == PIN_LO_ADDR)
    begin
      next_hrdata = pinLevel[31:0];
    end
    else if (dataAddr == PIN_HI_ADDR)
    begin
      next_hrdata = {1'b0, pinLevel[62:32]};
    end
    // readback is spelled out per register so the map does not lean on the write-side table
    else if (dataAddr == ADDR_W'(0 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[0];
      next_hrdata[HI_POS +: SEL_W] = sel[1];
    end
    else if (dataAddr == ADDR_W'(1 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[2];
      next_hrdata[HI_POS +: SEL_W] = sel[3];
    end
    else if (dataAddr == ADDR_W'(2 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[4];
      next_hrdata[HI_POS +: SEL_W] = sel[5];
    end
    else if (dataAddr == ADDR_W'(3 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[6];
      next_hrdata[HI_POS +: SEL_W] = sel[7];
    end
    else if (dataAddr == ADDR_W'(4 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[8];
      next_hrdata[HI_POS +: SEL_W] = sel[9];
    end
    else if (dataAddr == ADDR_W'(7 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[10];
      next_hrdata[HI_POS +: SEL_W] = sel[11];
    end
    else if (dataAddr == ADDR_W'(8 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[12];
    end
    else if (dataAddr == ADDR_W'(11 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[13];
      next_hrdata[HI_POS +: SEL_W] = sel[14];
    end
    else if (dataAddr == ADDR_W'(12 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[15];
      next_hrdata[HI_POS +: SEL_W] = sel[16];
    end
    else if (dataAddr == ADDR_W'(17 * REG_STRIDE))
    begin
      next_hrdata[HI_POS +: SEL_W] = sel[17];
    end
    else if (dataAddr == ADDR_W'(18 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[18];
      next_hrdata[HI_POS +: SEL_W] = sel[19];
    end
    else if (dataAddr == ADDR_W'(19 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[20];
      next_hrdata[HI_POS +: SEL_W] = sel[21];
    end
    else if (dataAddr == ADDR_W'(20 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[22];
      next_hrdata[HI_POS +: SEL_W] = sel[23];
    end
    else if (dataAddr == ADDR_W'(21 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[24];
      next_hrdata[HI_POS +: SEL_W] = sel[25];
    end
    else if (dataAddr == ADDR_W'(22 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[26];
      next_hrdata[HI_POS +: SEL_W] = sel[27];
    end
    else if (dataAddr == ADDR_W'(23 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[28];
      next_hrdata[HI_POS +: SEL_W] = sel[29];
    end
    else if (dataAddr == ADDR_W'(25 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[30];
      next_hrdata[HI_POS +: SEL_W] = sel[31];
    end
    else if (dataAddr == ADDR_W'(27 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[32];
      next_hrdata[HI_POS +: SEL_W] = sel[33];
    end
    else if (dataAddr == ADDR_W'(28 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[34];
      next_hrdata[HI_POS +: SEL_W] = sel[35];
    end
    else if (dataAddr == ADDR_W'(29 * REG_STRIDE))
    begin
      next_hrdata[LO_POS +: SEL_W] = sel[36];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hrdata <= '0;
    end
    else if (phase == PhReadWait)
    begin
      hrdata <= next_hrdata;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // a pin level changes only once the second and third stages agree, filtering one-cycle glitches
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinS1 <= PIN_LEVEL_RESET;
      pinS2 <= PIN_LEVEL_RESET;
      pinS3 <= PIN_LEVEL_RESET;
      pinLevel <= PIN_LEVEL_RESET;
    end
    else
    begin
      pinS1 <= remappablePin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinLevel <= (pinS2 & pinS3) | (pinLevel & (pinS2 ^ pinS3));
    end
  end

  // ------------------------------------------------------------
  // crossbar
  // ------------------------------------------------------------
  // codes past the last pin, the reset code among them, read as ground
  always_comb
  begin
    next_periphVec = '0;
    for (int i = 0; i < FIELD_COUNT; i++)
    begin
      if (sel[i] < SEL_W'(PIN_COUNT))
      begin
        next_periphVec[i] = pinLevel[sel[i]];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      periphVec <= '0;
    end
    else
    begin
      periphVec <= next_periphVec;
    end
  end

  // ------------------------------------------------------------
  // named peripheral inputs, field order of the register table
  // ------------------------------------------------------------
  assign periphIn.compareTrigger1 = periphVec[0];
  assign periphIn.extIrq1 = periphVec[1];
  assign periphIn.extIrq2 = periphVec[2];
  assign periphIn.extIrq3 = periphVec[3];
  assign periphIn.extIrq4 = periphVec[4];
  assign periphIn.compareTrigger2 = periphVec[5];
  assign periphIn.timer2ExtClock = periphVec[6];
  assign periphIn.timer3ExtClock = periphVec[7];
  assign periphIn.timer4ExtClock = periphVec[8];
  assign periphIn.timer5ExtClock = periphVec[9];
  assign periphIn.captureInput1 = periphVec[10];
  assign periphIn.captureInput2 = periphVec[11];
  assign periphIn.captureInput3 = periphVec[12];
  assign periphIn.compareFaultA = periphVec[13];
  assign periphIn.compareFaultB = periphVec[14];
  assign periphIn.ccpClockA = periphVec[15];
  assign periphIn.ccpClockB = periphVec[16];
  assign periphIn.uart3Receive = periphVec[17];
  assign periphIn.uart1Receive = periphVec[18];
  assign periphIn.uart1ClearToSend = periphVec[19];
  assign periphIn.uart2Receive = periphVec[20];
  assign periphIn.uart2ClearToSend = periphVec[21];
  assign periphIn.spi1DataIn = periphVec[22];
  assign periphIn.spi1ClockIn = periphVec[23];
  assign periphIn.spi1SelectIn = periphVec[24];
  assign periphIn.uart3ClearToSend = periphVec[25];
  assign periphIn.spi2DataIn = periphVec[26];
  assign periphIn.spi2ClockIn = periphVec[27];
  assign periphIn.spi2SelectIn = periphVec[28];
  assign periphIn.genericTimerClock = periphVec[29];
  assign periphIn.logicCellInputA = periphVec[30];
  assign periphIn.logicCellInputB = periphVec[31];
  assign periphIn.uart4Receive = periphVec[32];
  assign periphIn.uart4ClearToSend = periphVec[33];
  assign periphIn.spi3DataIn = periphVec[34];
  assign periphIn.spi3ClockIn = periphVec[35];
  assign periphIn.spi3SelectIn = periphVec[36];

endmodule

// file: design/pips_pkg.sv
/*
  pips_pkg: constants, register map and types for the peripheral input pin-select crossbar.
  assumes: one 250 mhz clock, word-aligned ahb-lite register access, 8-bit byte address.
*/
package pips_pkg;

  // ------------------------------------------------------------
  // field and pin geometry
  // ------------------------------------------------------------
  localparam int SEL_W = 6;
  localparam int FIELD_COUNT = 37;
  localparam int PIN_COUNT = 63;
  localparam int ADDR_W = 8;
  localparam int LO_POS = 0;
  localparam int HI_POS = 8;
  localparam logic [5:0] SEL_RESET = 6'h3f;
  localparam logic [62:0] PIN_LEVEL_RESET = 63'h0;
  localparam logic LOCK_RESET = 1'h0;
  localparam int LOCK_POS = 0;

  // ------------------------------------------------------------
  // register map: input_select_N sits at byte address 4*N
  // ------------------------------------------------------------
  localparam int REG_STRIDE = 4;
  localparam logic [7:0] LOCK_ADDR = 8'h80;
  localparam logic [7:0] PIN_LO_ADDR = 8'h84;
  localparam logic [7:0] PIN_HI_ADDR = 8'h88;

  // register number and high/low half of each field, field 0 first
  localparam int FIELD_REG [FIELD_COUNT] = '{
    0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 7, 7, 8, 11, 11, 12, 12, 17, 18, 18,
    19, 19, 20, 20, 21, 21, 22, 22, 23, 23, 25, 25, 27, 27, 28, 28, 29};
  localparam bit FIELD_HI [FIELD_COUNT] = '{
    0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1, 0, 1, 1, 0, 1,
    0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};

  // ------------------------------------------------------------
  // bus phase tracking
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PhIdle, PhWrite, PhReadWait, PhReadDone} pips_phase_type;

  // ------------------------------------------------------------
  // routed peripheral inputs, field 0 in bit 0
  // ------------------------------------------------------------
  typedef struct packed {
    logic spi3SelectIn, spi3ClockIn, spi3DataIn, uart4ClearToSend, uart4Receive;
    logic logicCellInputB, logicCellInputA, genericTimerClock, spi2SelectIn, spi2ClockIn;
    logic spi2DataIn, uart3ClearToSend, spi1SelectIn, spi1ClockIn, spi1DataIn;
    logic uart2ClearToSend, uart2Receive, uart1ClearToSend, uart1Receive, uart3Receive;
    logic ccpClockB, ccpClockA, compareFaultB, compareFaultA, captureInput3;
    logic captureInput2, captureInput1, timer5ExtClock, timer4ExtClock, timer3ExtClock;
    logic timer2ExtClock, compareTrigger2, extIrq4, extIrq3, extIrq2, extIrq1, compareTrigger1;
  } pips_periph_type;

endpackage

// file: dv/pips_input_select_properties.sv
/*
  checker for the pin-select register bus, lock bit and routed outputs.
  assumes: bound onto pips_input_select, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module pips_input_select_properties
  import pips_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic rst_n,
  // bus
  input logic hsel,
  input logic [pips_pkg::ADDR_W-1:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  // routed side
  input pips_pkg::pips_periph_type periphIn,
  input logic pinMapLock
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd = hsel && htrans[1] && hready && !hwrite;
  wire wr = hsel && htrans[1] && hready && hwrite;
  wire lockWr = wr && haddr == LOCK_ADDR;
  a_resp_okay: assert property (hresp == 1'h0) else $error("hresp not okay");
  a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_fast: assert property (wr |=> hreadyout) else $error("write stalled");
  a_reset_clear: assert property ($rose(rst_n) |-> periphIn == '0 && !pinMapLock) else $error("reset state");
  a_lock_set: assert property (lockWr ##1 1'b1 |=> pinMapLock == $past(hwdata[0])) else $error("lock lost");
  a_lock_cause: assert property ($changed(pinMapLock) |-> $past(lockWr, 2)) else $error("lock moved alone");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("hrdata moved");
  a_unmapped_zero: assert property (rd && haddr == 8'h7c |-> ##2 hrdata == '0) else $error("unmapped read");
  a_spare_zero: assert property (rd && haddr < LOCK_ADDR |-> ##2 (hrdata & 32'hffffc0c0) == '0) else $error("spare");
  c_read: cover property (rd);
  c_locked_write: cover property (pinMapLock && wr && haddr < LOCK_ADDR);
  c_route: cover property ($rose(periphIn.uart1Receive));
endmodule
bind pips_input_select pips_input_select_properties u_props (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .periphIn, .pinMapLock);

// file: dv/pips_input_select_tb.sv
/*
  bench: ahb-lite register tasks, reset values, field routing, lock, second reset.
  assumes: one slave, hready looped back from hreadyout.
*/
`timescale 1ns/1ps
module pips_input_select_tb;
  import pips_pkg::*;
  // ------------------------------------------------------------
  // signals, partner, design
  // ------------------------------------------------------------
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, pinMapLock;
  logic [7:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, q, e;
  logic [62:0] want = '1, pins;
  pips_periph_type periphIn;
  int errors = 0, n_checks = 0;
  initial forever #2 clk = ~clk;
  pips_pin_model #(.SLOW(1'b1)) far (.clk, .want, .remappablePin(pins));
  pips_input_select dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .remappablePin(pins), .periphIn, .pinMapLock);
  task automatic check(input string what, input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    bus(8'h7c, 0, 0);
    check("grounded", periphIn, '0);
    $display("test grounded done");
    for (int r = 0; r < 32; r++)
    begin
      e = '0;
      for (int f = 0; f < FIELD_COUNT; f++)
        if (FIELD_REG[f] == r) e |= 32'h3f << (FIELD_HI[f] ? HI_POS : LO_POS);
      bus(8'(r * 4), 0, 0);
      check("reset word", q, e);
      bus(8'(r * 4), 1, 32'hffffe5ea);
      bus(8'(r * 4), 0, 0);
      check("masked word", q, e & 32'h252a);
    end
    $display("test registers done");
    for (int f = 0; f < FIELD_COUNT; f++)
    begin
      want <= 63'h1 << f;
      bus(8'(FIELD_REG[f] * 4), 1, FIELD_HI[f] ? 32'h3f | f << 8 : 32'h3f00 | f);
      repeat (8) @(posedge clk);
      check("routed", periphIn, 37'h1 << f);
    end
    bus(PIN_LO_ADDR, 0, 0);
    check("pins low", q, 0);
    bus(PIN_HI_ADDR, 0, 0);
    check("pins high", q, 32'h10);
    $display("test routing done");
    bus(LOCK_ADDR, 0, 0);
    check("lock reset", q, 0);
    bus(8'h00, 1, 32'h0102);
    bus(LOCK_ADDR, 1, 1);
    bus(8'h00, 1, 32'h0304);
    bus(8'h00, 0, 0);
    check("locked word", {q, pinMapLock}, {32'h0102, 1'h1});
    $display("test lock done");
    rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    bus(8'h00, 0, 0);
    check("second reset", {q, pinMapLock}, {32'h3f3f, 1'h0});
    $display("test second reset done");
    wrap_up;
  end
endmodule

// file: dv/pips_pin_model.sv
/*
  far-side pin driver: shows the levels the bench wants, one or two edges late.
  assumes: levels are held well past the two-cycle pin filter.
*/
`timescale 1ns/1ps
module pips_pin_model #(parameter bit SLOW = 1'b0)
(
  // clock
  input logic clk,
  // wanted and driven pin levels
  input logic [pips_pkg::PIN_COUNT-1:0] want,
  output logic [pips_pkg::PIN_COUNT-1:0] remappablePin = '0
);
  // ------------------------------------------------------------
  // slow mode adds a stage, as a far pad would
  // ------------------------------------------------------------
  logic [pips_pkg::PIN_COUNT-1:0] lagged = '0;
  always @(posedge clk)
  begin
    lagged <= want;
    remappablePin <= SLOW ? lagged : want;
  end
endmodule
